// ---- hw/pfs_function_select.sv ----
// Purpose: port F/G pin function select, wishbone slave
// Assumes: nrst is the power-on reset only; other resets never reach here
// Notes:   one-wait-state ack; unmapped reads return zero with ack
// Contract
// - F control: 32-bit RW, power-on clears
// - G control: 28-bit RW (bits 27:0), power-on clears
// - F8-15: in, out, alt; 10 reserved
// - F0-7: in, out only
// - G bits 31:28 read zero
// - G11-13: in, out only
// - G9-10: in, out, alt; 10 reserved
// - G8: in, out only
// - G0-7: 00 is input/analog
// - analog pins back to input after conversion
`timescale 1ns/1ps
`default_nettype none
module pfs_function_select
	import pfs_pkg::*;
(
	// clock and power-on reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// converter status, same clock domain
	input  wire logic [7:0]  convStart,
	input  wire logic [7:0]  convDone,
	// port F pin control
	output logic [15:0]      portFOutEn,
	output logic [15:0]      portFAltEn,
	// port G pin control
	output logic [15:0]      portGOutEn,
	output logic [15:0]      portGAltEn,
	output logic [7:0]       analogInputPin,
	// reserved code present in either register
	output logic             rsvdCode
);

	// ********************************
	// bus request
	// ********************************
	pfs_wb_req_s req;
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
		adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

	// byte-lane merge used by both control registers
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = wr[8*b +: 8];
		end
		return r;
	endfunction

	// ********************************
	// register state
	// ********************************
	logic [31:0] portFCtrl_q, portFCtrl_d;
	logic [31:0] portGCtrl_q, portGCtrl_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [7:0]  convBusy_q, convBusy_d;
	logic        take;
	logic        commit;

	// one access per ack; ack drops the cycle after it was given
	assign take = req.cyc && req.stb && !ack_q;

	// writes land at the edge where the master sees ack, not one earlier
	assign commit = req.cyc && req.stb && req.we && ack_q;

	// next-state for registers and bus answer
	always_comb begin
		portFCtrl_d = portFCtrl_q;
		portGCtrl_d = portGCtrl_q;
		ack_d       = take;
		rdat_d      = 32'h00000000;
		if (commit) begin
			unique case (req.adr)
				PFS_OFF_PORT_F: portFCtrl_d = laneMerge(portFCtrl_q, req.dat,
					req.sel);
				PFS_OFF_PORT_G: portGCtrl_d = laneMerge(portGCtrl_q, req.dat,
					req.sel) & PFS_PORT_G_RD_MASK;
				default: ;
			endcase
		end
		if (take && !req.we) begin
			unique case (req.adr)
				PFS_OFF_PORT_F: rdat_d = portFCtrl_q;
				PFS_OFF_PORT_G: rdat_d = portGCtrl_q & PFS_PORT_G_RD_MASK;
				PFS_OFF_CONV:   rdat_d = {24'h000000, convBusy_q};
				default:        rdat_d = 32'h00000000;
			endcase
		end
	end

	// only the power-on reset clears these; otherwise they load the next-state values above
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			portFCtrl_q <= PFS_RST_PORT_F;
			portGCtrl_q <= PFS_RST_PORT_G;
			ack_q       <= 1'b0;
			rdat_q      <= 32'h00000000;
		end else begin
			portFCtrl_q <= portFCtrl_d;
			portGCtrl_q <= portGCtrl_d;
			ack_q       <= ack_d;
			rdat_q      <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ********************************
	// analog conversion tracking
	// ********************************
	// no control bit: pin is converter input only while busy
	always_comb begin
		convBusy_d = (convBusy_q | convStart) & ~convDone;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			convBusy_q <= 8'h00;
		end else begin
			convBusy_q <= convBusy_d;
		end
	end

	// ********************************
	// pin decode
	// ********************************
	logic [15:0] fOut, fAlt, fRsvd, gOut, gAlt, gRsvd;

	// F0-7 have no alternate; F8-15 do
	pfs_port #(
		.ALT_LO    (PFS_F_ALT_LO),
		.ALT_HI    (PFS_PINS - 1),
		.ANALOG_HI (-1),
		.NPINS     (PFS_PINS)
	) uPortF (
		.ctrl  (portFCtrl_q),
		.outEn (fOut),
		.altEn (fAlt),
		.rsvd  (fRsvd)
	);

	// G0-7 analog, G8 and G11-13 plain, G9-10 alternate
	pfs_port #(
		.ALT_LO    (PFS_G_ALT_LO),
		.ALT_HI    (PFS_G_ALT_HI),
		.ANALOG_HI (PFS_G_ANALOG_HI),
		.NPINS     (PFS_PINS)
	) uPortG (
		.ctrl  (portGCtrl_q),
		.outEn (gOut),
		.altEn (gAlt),
		.rsvd  (gRsvd)
	);

	// ********************************
	// registered pin outputs
	// ********************************
	logic [15:0] fOut_q, fAlt_q, gOut_q, gAlt_q;
	logic [7:0]  an_q, an_d;
	logic        rsvd_q, rsvd_d;

	// pins 14,15 of G do not exist; reserved-code pins stay input
	always_comb begin
		an_d   = convBusy_q & ~gRsvd[7:0];
		rsvd_d = (|fRsvd) | (|gRsvd[13:0]);
	end

	// outputs straight from flops
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fOut_q <= 16'h0000;
			fAlt_q <= 16'h0000;
			gOut_q <= 16'h0000;
			gAlt_q <= 16'h0000;
			an_q   <= 8'h00;
			rsvd_q <= 1'b0;
		end else begin
			fOut_q <= fOut;
			fAlt_q <= fAlt;
			gOut_q <= {2'h0, gOut[13:0]};
			gAlt_q <= {2'h0, gAlt[13:0]};
			an_q   <= an_d;
			rsvd_q <= rsvd_d;
		end
	end

	assign portFOutEn     = fOut_q;
	assign portFAltEn     = fAlt_q;
	assign portGOutEn     = gOut_q;
	assign portGAltEn     = gAlt_q;
	assign analogInputPin = an_q;
	assign rsvdCode       = rsvd_q;

endmodule
`default_nettype wire

// ---- hw/pfs_pin_decode.sv ----
// Purpose: decode one pin's two-bit mode field into its function
// Assumes: pin capability given as parameters
// Notes:   reserved codes report PFS_FN_RSVD, pin then kept as input
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_decode
	import pfs_pkg::*;
#(
	parameter bit HAS_ALT    = 1'b0,
	parameter bit IS_ANALOG  = 1'b0
) (
	// mode field
	input  wire logic [1:0] mode,
	// decoded function
	output pfs_fn_e         fn
);

	// ********************************
	// decode
	// ********************************
	// analog pins accept only 00; alt only where the pin has one
	always_comb begin
		fn = PFS_FN_RSVD;
		if (IS_ANALOG) begin
			if (mode == PFS_MODE_IN) fn = PFS_FN_IN;
		end else begin
			unique case (mode)
				PFS_MODE_IN:  fn = PFS_FN_IN;
				PFS_MODE_OUT: fn = PFS_FN_OUT;
				PFS_MODE_ALT: fn = HAS_ALT ? PFS_FN_ALT : PFS_FN_RSVD;
				default:      fn = PFS_FN_RSVD;
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- hw/pfs_pkg.sv ----
// Purpose: shared constants and types for the port F/G function select block
// Assumes: classic wishbone slave, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
package pfs_pkg;

	// ********************************
	// register map
	// ********************************
	localparam logic [3:0]  PFS_OFF_PORT_F      = 4'h0;
	localparam logic [3:0]  PFS_OFF_PORT_G      = 4'h4;
	localparam logic [3:0]  PFS_OFF_CONV        = 4'h8;
	localparam logic [31:0] PFS_RST_PORT_F      = 32'h00000000;
	localparam logic [31:0] PFS_RST_PORT_G      = 32'h00000000;
	localparam logic [31:0] PFS_PORT_G_RD_MASK  = 32'h0FFFFFFF;
	localparam int          PFS_PINS            = 16;
	localparam int          PFS_F_ALT_LO        = 8;
	localparam int          PFS_G_ALT_LO        = 9;
	localparam int          PFS_G_ALT_HI        = 10;
	localparam int          PFS_G_ANALOG_HI     = 7;

	// ********************************
	// mode codes and pin function
	// ********************************
	localparam logic [1:0]  PFS_MODE_IN         = 2'h0;
	localparam logic [1:0]  PFS_MODE_OUT        = 2'h1;
	localparam logic [1:0]  PFS_MODE_ALT        = 2'h3;

	typedef enum logic [3:0] {
		PFS_FN_IN     = 4'h1,
		PFS_FN_OUT    = 4'h2,
		PFS_FN_ALT    = 4'h4,
		PFS_FN_RSVD   = 4'h8
	} pfs_fn_e;

	// classic wishbone request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pfs_wb_req_s;

endpackage

// ---- hw/pfs_port.sv ----
// Purpose: one port's pin decode array, packed into per-pin enables
// Assumes: 16 pins, pin n field at bits 2n+1:2n
// Notes:   reserved code leaves the pin as input, flagged to caller
`timescale 1ns/1ps
`default_nettype none
module pfs_port
	import pfs_pkg::*;
#(
	parameter int ALT_LO    = 16,
	parameter int ALT_HI    = 15,
	parameter int ANALOG_HI = -1,
	parameter int NPINS     = 16
) (
	// control word
	input  wire logic [31:0]      ctrl,
	// per-pin outputs
	output logic [NPINS-1:0]      outEn,
	output logic [NPINS-1:0]      altEn,
	output logic [NPINS-1:0]      rsvd
);

	// ********************************
	// pins
	// ********************************
	genvar n;
	generate
		for (n = 0; n < NPINS; n++) begin : gPin
			pfs_fn_e fn;
			pfs_pin_decode #(
				.HAS_ALT   ((n >= ALT_LO) && (n <= ALT_HI)),
				.IS_ANALOG (n <= ANALOG_HI)
			) uDec (
				.mode (ctrl[2*n+1 -: 2]),
				.fn   (fn)
			);
			assign outEn[n] = (fn == PFS_FN_OUT);
			assign altEn[n] = (fn == PFS_FN_ALT);
			assign rsvd[n]  = (fn == PFS_FN_RSVD);
		end
	endgenerate

endmodule
`default_nettype wire

// ---- testbench/pfs_function_select_bench.sv ----
// Purpose: directed bench for pfs_function_select
// Assumes: one-wait-state wishbone slave
// Notes:   ack sampled at the rising edge, request released there
`timescale 1ns/1ps
`default_nettype none
module pfs_function_select_bench
	import pfs_pkg::*;
;
	logic        coreClk;
	logic        nrst;
	logic        ack;
	logic        rsvd;
	pfs_wb_req_s req;
	logic [31:0] datO;
	logic [31:0] rd;
	logic [7:0]  cStart;
	logic [7:0]  cDone;
	logic [7:0]  aPin;
	logic [15:0] fOut;
	logic [15:0] fAlt;
	logic [15:0] gOut;
	logic [15:0] gAlt;
	int          errors;
	int          nChecks;
	pfs_function_select pfs_function_select_inst (
		.core_clk(coreClk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
		.wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
		.wb_dat_o(datO), .wb_ack_o(ack), .convStart(cStart), .convDone(cDone),
		.portFOutEn(fOut), .portFAltEn(fAlt), .portGOutEn(gOut), .portGAltEn(gAlt),
		.analogInputPin(aPin), .rsvdCode(rsvd));
	// ********
	// tasks
	// ********
	task automatic conclude();
		if (errors == 0 && nChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// bounded wait, a hung slave ends the run
	task automatic xfer(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] s);
		int i;
		@(posedge coreClk);
		req <= '{1'b1, 1'b1, w, a, s, d};
		@(posedge coreClk);
		for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge coreClk);
		if (ack !== 1'b1) begin
			errors++;
			conclude();
		end else begin
			rd = datO;
			req <= '0;
		end
	endtask
	task automatic rdc(string nm, logic [3:0] a, logic [31:0] e);
		xfer(1'b0, a, 32'h00000000, 4'hF);
		chk(nm, e, rd);
	endtask
	task automatic settle();
		repeat (2) @(negedge coreClk);
	endtask
	task automatic pulse(logic [7:0] s, logic [7:0] d);
		@(posedge coreClk);
		cStart <= s;
		cDone <= d;
		@(posedge coreClk);
		cStart <= 8'h00;
		cDone <= 8'h00;
		settle();
	endtask
	initial begin
		coreClk = 1'b0;
		forever #50 coreClk = ~coreClk;
	end
	// ********
	// sequence
	// ********
	initial begin
		{nrst, req, cStart, cDone, errors, nChecks} = '0;
		repeat (2) @(posedge coreClk);
		nrst <= 1'b1;
		rdc("f_rst", PFS_OFF_PORT_F, PFS_RST_PORT_F);
		rdc("g_rst", PFS_OFF_PORT_G, PFS_RST_PORT_G);
		xfer(1'b1, PFS_OFF_PORT_F, 32'hDDDD5555, 4'hF);
		settle();
		rdc("f_rb", PFS_OFF_PORT_F, 32'hDDDD5555);
		chk("f_out", 32'h55FF, {16'h0000, fOut});
		chk("f_alt", 32'hAA00, {16'h0000, fAlt});
		chk("rsvd", 32'h0, {31'h0, rsvd});
		// lane 0 only, pins 3..0 get the reserved code
		xfer(1'b1, PFS_OFF_PORT_F, 32'hFFFFFFFF, 4'h1);
		settle();
		rdc("f_lane", PFS_OFF_PORT_F, 32'hDDDD55FF);
		chk("f_rsv", 32'h55F0, {16'h0000, fOut});
		chk("rsvd_f", 32'h1, {31'h0, rsvd});
		xfer(1'b1, PFS_OFF_PORT_F, 32'h00000000, 4'hF);
		xfer(1'b1, PFS_OFF_PORT_G, 32'hF5750000, 4'hF);
		settle();
		rdc("g_rb", PFS_OFF_PORT_G, 32'h05750000);
		chk("g_out", 32'h3B00, {16'h0000, gOut});
		chk("g_alt", 32'h0400, {16'h0000, gAlt});
		chk("g_rsvd", 32'h0, {31'h0, rsvd});
		pulse(8'hFF, 8'h00);
		chk("an_on", 32'hFF, {24'h0, aPin});
		rdc("busy", PFS_OFF_CONV, 32'h000000FF);
		// busy bits are read-only, a write must not disturb them
		xfer(1'b1, PFS_OFF_CONV, 32'h00000000, 4'hF);
		rdc("busy_ro", PFS_OFF_CONV, 32'h000000FF);
		pulse(8'h00, 8'h0F);
		chk("an_half", 32'hF0, {24'h0, aPin});
		pulse(8'h10, 8'hF0);
		chk("an_off", 32'h00, {24'h0, aPin});
		xfer(1'b1, PFS_OFF_PORT_G, 32'h05750001, 4'hF);
		settle();
		chk("g_rsv", 32'h1, {31'h0, rsvd});
		chk("g_rsv_out", 32'h3B00, {16'h0000, gOut});
		// pin 0 holds a reserved code, so it must not reach the converter
		pulse(8'h01, 8'h00);
		chk("an_rsv", 32'h00, {24'h0, aPin});
		xfer(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
		rdc("unmap", 4'hC, 32'h00000000);
		rdc("g_keep", PFS_OFF_PORT_G, 32'h05750001);
		@(posedge coreClk);
		nrst <= 1'b0;
		repeat (2) @(posedge coreClk);
		nrst <= 1'b1;
		chk("g_out_por", 32'h0, {16'h0000, gOut});
		rdc("g_por", PFS_OFF_PORT_G, PFS_RST_PORT_G);
		conclude();
	end
endmodule
bind pfs_function_select pfs_function_select_chk pfs_function_select_chk_inst (
	.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.convDone(convDone), .portFOutEn(portFOutEn), .portFAltEn(portFAltEn),
	.portGOutEn(portGOutEn), .portGAltEn(portGAltEn), .analogInputPin(analogInputPin));
`default_nettype wire

// ---- testbench/pfs_function_select_chk.sv ----
// Purpose: port-level checks for pfs_function_select
// Assumes: nrst is the only reset
// Notes:   bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module pfs_function_select_chk
	import pfs_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        nrst,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pins
	input wire logic [7:0]  convDone,
	input wire logic [15:0] portFOutEn,
	input wire logic [15:0] portFAltEn,
	input wire logic [15:0] portGOutEn,
	input wire logic [15:0] portGAltEn,
	input wire logic [7:0]  analogInputPin
);
	// ********
	// checks
	// ********
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// one wait state, then a single pulse
	ack_on_req_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	g_top_rd_a: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == PFS_OFF_PORT_G |-> wb_dat_o[31:28] == 4'h0)
		else $error("port g top bits set");
	f_low_alt_a: assert property (
		portFAltEn[7:0] == 8'h00)
		else $error("port f low alt");
	f_excl_a: assert property (
		(portFOutEn & portFAltEn) == 16'h0000)
		else $error("port f out and alt");
	g_alt_pins_a: assert property (
		(portGAltEn & 16'hF9FF) == 16'h0000)
		else $error("port g alt pin");
	g_out_pins_a: assert property (
		portGOutEn[15:14] == 2'h0 && portGOutEn[7:0] == 8'h00)
		else $error("port g out pin");
	// busy clears one edge after done, the pin flop one edge later
	conv_done_a: assert property (
		|convDone |-> ##2 (analogInputPin & $past(convDone, 2)) == 8'h00)
		else $error("analog pin kept");
	cover property (wb_ack_o && wb_we_i);
	cover property (|portFAltEn);
	cover property (|analogInputPin);
endmodule
`default_nettype wire
